// [common/ubl_pkg.sv]
// Purpose: shared constants and types of the update block loader
// Assumes: 32-bit Avalon-MM register slave, 32-bit fetch port to memory
// Notes: register offsets are byte addresses, one aligned word each
//
// Contract
// RULE1: an update block is exactly 2048 bytes, header then payload
// RULE2: first 48 bytes are the header; its meaning follows the header version
// RULE3: header version is the word at offset 0; first defined value is one
// RULE4: revision word at offset 4 becomes the reported signature of the active update
// RULE5: date word at offset 8 packs month, day, year as digits
// RULE6: target word at offset 12 must equal the processor identity
// RULE7: checksum word at offset 16 makes all 512 words sum to zero
// RULE8: loader revision word at offset 20; first defined value is one
// RULE9: 24 reserved bytes at offset 24, then 2000 payload bytes at 48
// RULE10: refuse blocks for other steppings and blocks with tampered contents
// RULE11: load starts on register write to index 79h, low=payload address, high=0
// RULE12: payload address needs no byte or word alignment
// RULE13: in real mode firmware keeps payload inside one segment and limit
// RULE14: with paging on firmware keeps every payload page present
// RULE15: hard reset discards any loaded update
// RULE16: INIT leaves a loaded update in effect
// RULE17: loading the same update repeatedly is harmless
// RULE18: firmware reloads after every hard reset during power_on_self_test
// RULE19: processor runs correctly with no update loaded
// RULE20: firmware should offer a setup option to enable or disable loading
// RULE21: the load sequence is chosen by the loader revision value
// RULE22: a header version of all ones marks an unused slot
// RULE23: a rejected update keeps the previous update and signature, no fault
package ubl_pkg;
  localparam int unsigned BLOCK_BYTES = 2048;
  localparam int unsigned HDR_BYTES = 48;
  localparam int unsigned PAYLOAD_BYTES = 2000;
  localparam int unsigned BLOCK_WORDS = BLOCK_BYTES / 4;
  localparam int unsigned HDR_WORDS = HDR_BYTES / 4;
  localparam int unsigned PAYLOAD_WORDS = PAYLOAD_BYTES / 4;
  localparam int unsigned IDX_W = 9;
  localparam logic [IDX_W-1:0] W_HDR_VER = 9'h000;
  localparam logic [IDX_W-1:0] W_REV = 9'h001;
  localparam logic [IDX_W-1:0] W_DATE = 9'h002;
  localparam logic [IDX_W-1:0] W_TARGET = 9'h003;
  localparam logic [IDX_W-1:0] W_CSUM = 9'h004;
  localparam logic [IDX_W-1:0] W_LDR = 9'h005;
  localparam logic [IDX_W-1:0] W_PAYLOAD = 9'h00C;
  localparam logic [IDX_W-1:0] W_LAST = 9'h1FF;
  localparam logic [31:0] HDR_OFFSET = 32'h0000_0030;
  localparam logic [31:0] HDR_VERSION_1 = 32'h0000_0001;
  localparam logic [31:0] LOADER_REV_1 = 32'h0000_0001;
  localparam logic [31:0] HDR_UNUSED = 32'hFFFF_FFFF;
  localparam logic [31:0] MSR_TRIGGER = 32'h0000_0079;
  localparam logic [7:0] REG_MSR_IDX = 8'h00;
  localparam logic [7:0] REG_DATA_LO = 8'h04;
  localparam logic [7:0] REG_DATA_HI = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SIGN = 8'h14;
  localparam logic [7:0] REG_IDENT = 8'h18;
  localparam int unsigned CMD_EXEC = 0;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_ACTIVE = 1;
  localparam int unsigned ST_LAST_OK = 2;
  localparam int unsigned ST_REJ_TRIG = 3;
  localparam int unsigned ST_REJ_VER = 4;
  localparam int unsigned ST_REJ_TGT = 5;
  localparam int unsigned ST_REJ_SUM = 6;
  localparam int unsigned ST_REJ_LDR = 7;
  localparam int unsigned ST_UNUSED = 8;
  localparam int unsigned ST_ABORT = 9;

  typedef enum logic [3:0] {
    UBL_IDLE = 4'b0001,
    UBL_FETCH = 4'b0010,
    UBL_CHECK = 4'b0100,
    UBL_COMMIT = 4'b1000
  } ubl_state_e;

  typedef struct packed {
    logic [31:0] ver;
    logic [31:0] rev;
    logic [31:0] target;
    logic [31:0] ldr;
  } ubl_hdr_s;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } ubl_fetch_s;
endpackage : ubl_pkg

// [hdl/ubl_sync.sv]
// Purpose: two-flop synchroniser for a level from a pin
// Assumes: input is asynchronous to i_sys_clk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module ubl_sync (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : ubl_sync

// [hdl/ubl_mem.sv]
// Purpose: two-bank payload store, one write and one registered read port
// Assumes: single clock, write and read may hit the same word
// Notes: no reset on the array; only valid banks are ever read by the core
`timescale 1ns/1ps
module ubl_mem #(
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned AW = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);
  logic [31:0] mem_q [DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule : ubl_mem

// [hdl/ubl_top.sv]
// Purpose: correction block loader: fetches a 2048-byte block, checks it, activates payload
// Assumes: fetch port returns one 32-bit word at any byte address per request
// Notes: i_rst is the hard reset; i_init is the processor INIT pin
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module ubl_top #(
  parameter logic [31:0] P_CPU_ID = 32'h0000_0A5C // arbitrary identity value
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_init,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output ubl_pkg::ubl_fetch_s o_fetch,
  input wire logic i_fetch_valid,
  input wire logic [31:0] i_fetch_data,
  input wire logic [8:0] i_patch_raddr,
  output logic [31:0] o_patch_rdata,
  output logic o_patch_active
);
  ubl_pkg::ubl_state_e state_q;
  ubl_pkg::ubl_hdr_s hdr_q;
  logic [31:0] msr_idx_q;
  logic [31:0] data_lo_q;
  logic [31:0] data_hi_q;
  logic [31:0] sum_q;
  logic [31:0] sign_q;
  logic [9:0] status_q;
  logic [8:0] idx_q;
  logic bank_q;
  logic wait_q;
  logic init_s;
  logic acc;
  logic exec;
  logic go;
  logic hi_bad;
  logic ok;
  logic ver_bad;
  logic tgt_bad;
  logic sum_bad;
  logic ldr_bad;
  logic [31:0] sum_next;
  logic [31:0] be_mask;
  logic mem_we;
  logic [9:0] mem_waddr;

  ubl_sync u_init_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_init),
    .o_sync(init_s)
  );

  // bank_q holds the live payload; the other bank is staging, so a
  // rejected block never disturbs what is running
  ubl_mem #(.DEPTH(1024), .AW(10)) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(i_fetch_data),
    .i_raddr({bank_q, i_patch_raddr}),
    .o_rdata(o_patch_rdata)
  );

  // access accepted on the edge where waitrequest is low
  assign acc = (i_avs_read | i_avs_write) & ~wait_q;
  assign exec = acc & i_avs_write & (i_avs_address == ubl_pkg::REG_CMD) &
    i_avs_writedata[ubl_pkg::CMD_EXEC] & i_avs_byteenable[0];
  assign hi_bad = data_hi_q != 32'h0000_0000; // RULE11
  // a trigger while busy is dropped; other indices are ignored here
  assign go = exec & (msr_idx_q == ubl_pkg::MSR_TRIGGER) & ~hi_bad &
    (state_q == ubl_pkg::UBL_IDLE); // RULE11

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
    end
  end

  // registered waitrequest: every access answers one cycle after it rises
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((i_avs_read | i_avs_write) & wait_q);
    end
  end

  assign o_avs_waitrequest = wait_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      msr_idx_q <= 32'h0000_0000;
      data_lo_q <= 32'h0000_0000;
      data_hi_q <= 32'h0000_0000;
    end else if (acc && i_avs_write) begin
      unique case (i_avs_address)
        ubl_pkg::REG_MSR_IDX: begin
          msr_idx_q <= (msr_idx_q & ~be_mask) | (i_avs_writedata & be_mask);
        end
        ubl_pkg::REG_DATA_LO: begin
          data_lo_q <= (data_lo_q & ~be_mask) | (i_avs_writedata & be_mask);
        end
        ubl_pkg::REG_DATA_HI: begin
          data_hi_q <= (data_hi_q & ~be_mask) | (i_avs_writedata & be_mask);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && wait_q) begin
      unique case (i_avs_address)
        ubl_pkg::REG_MSR_IDX: o_avs_readdata <= msr_idx_q;
        ubl_pkg::REG_DATA_LO: o_avs_readdata <= data_lo_q;
        ubl_pkg::REG_DATA_HI: o_avs_readdata <= data_hi_q;
        ubl_pkg::REG_STATUS: o_avs_readdata <= {22'h00_0000, status_q};
        ubl_pkg::REG_SIGN: o_avs_readdata <= sign_q;
        ubl_pkg::REG_IDENT: o_avs_readdata <= P_CPU_ID;
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // verdict on the whole block; header fields are meaningful only for
  // header version one and loader revision one
  assign ver_bad = hdr_q.ver != ubl_pkg::HDR_VERSION_1; // RULE2 RULE3
  assign ldr_bad = hdr_q.ldr != ubl_pkg::LOADER_REV_1; // RULE8 RULE21
  assign tgt_bad = hdr_q.target != P_CPU_ID; // RULE6 RULE10
  assign sum_bad = sum_q != 32'h0000_0000; // RULE10
  assign ok = ~ver_bad & ~ldr_bad & ~tgt_bad & ~sum_bad;
  assign sum_next = sum_q + i_fetch_data;

  // payload words 12..511 land in the staging bank
  assign mem_we = (state_q == ubl_pkg::UBL_FETCH) & i_fetch_valid &
    (idx_q >= ubl_pkg::W_PAYLOAD); // RULE9
  assign mem_waddr = {~bank_q, 9'(idx_q - ubl_pkg::W_PAYLOAD)};

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ubl_pkg::UBL_IDLE;
    end else if (init_s) begin
      state_q <= ubl_pkg::UBL_IDLE; // RULE16
    end else begin
      unique case (state_q)
        ubl_pkg::UBL_IDLE: begin
          if (go) begin
            state_q <= ubl_pkg::UBL_FETCH;
          end
        end
        ubl_pkg::UBL_FETCH: begin
          if (i_fetch_valid && idx_q == ubl_pkg::W_LAST) begin
            state_q <= ubl_pkg::UBL_CHECK; // RULE1
          end
        end
        ubl_pkg::UBL_CHECK: begin
          state_q <= ok ? ubl_pkg::UBL_COMMIT : ubl_pkg::UBL_IDLE; // RULE10 RULE23
        end
        ubl_pkg::UBL_COMMIT: begin
          state_q <= ubl_pkg::UBL_IDLE;
        end
        default: begin
          state_q <= ubl_pkg::UBL_IDLE;
        end
      endcase
    end
  end

  // fetch walks the block one word at a time from payload start minus 48;
  // the address is used as given, so any byte alignment is accepted
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch <= '0;
      idx_q <= '0;
    end else if (init_s) begin
      o_fetch.req <= 1'b0;
    end else if (go) begin
      o_fetch.req <= 1'b1;
      o_fetch.addr <= data_lo_q - ubl_pkg::HDR_OFFSET; // RULE11 RULE12
      idx_q <= '0;
    end else if (state_q == ubl_pkg::UBL_FETCH && i_fetch_valid) begin
      o_fetch.addr <= o_fetch.addr + 32'h0000_0004;
      idx_q <= idx_q + 9'h001;
      if (idx_q == ubl_pkg::W_LAST) begin
        o_fetch.req <= 1'b0; // RULE1
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sum_q <= 32'h0000_0000;
      hdr_q <= '0;
    end else if (go) begin
      sum_q <= 32'h0000_0000;
    end else if (state_q == ubl_pkg::UBL_FETCH && i_fetch_valid) begin
      sum_q <= sum_next; // RULE10
      unique case (idx_q)
        ubl_pkg::W_HDR_VER: hdr_q.ver <= i_fetch_data; // RULE3
        ubl_pkg::W_REV: hdr_q.rev <= i_fetch_data; // RULE4
        ubl_pkg::W_TARGET: hdr_q.target <= i_fetch_data; // RULE6
        ubl_pkg::W_LDR: hdr_q.ldr <= i_fetch_data; // RULE8
        default: begin
        end
      endcase
    end
  end

  // hard reset drops the live update; INIT does not touch it; a repeat
  // load of the same block lands in the same state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_patch_active <= 1'b0; // RULE15 RULE19
      sign_q <= 32'h0000_0000;
      bank_q <= 1'b0;
    end else if (state_q == ubl_pkg::UBL_COMMIT && !init_s) begin
      o_patch_active <= 1'b1; // RULE17
      sign_q <= hdr_q.rev; // RULE4
      bank_q <= ~bank_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= '0;
    end else begin
      status_q[ubl_pkg::ST_BUSY] <= (state_q != ubl_pkg::UBL_IDLE) | go;
      status_q[ubl_pkg::ST_ACTIVE] <= o_patch_active;
      if (exec && msr_idx_q == ubl_pkg::MSR_TRIGGER && state_q == ubl_pkg::UBL_IDLE) begin
        status_q[9:2] <= '0;
        status_q[ubl_pkg::ST_REJ_TRIG] <= hi_bad; // RULE11 RULE23
      end else if (init_s && state_q != ubl_pkg::UBL_IDLE) begin
        status_q[ubl_pkg::ST_ABORT] <= 1'b1;
      end else if (state_q == ubl_pkg::UBL_CHECK) begin
        status_q[ubl_pkg::ST_LAST_OK] <= ok;
        status_q[ubl_pkg::ST_REJ_VER] <= ver_bad;
        status_q[ubl_pkg::ST_REJ_TGT] <= tgt_bad; // RULE10
        status_q[ubl_pkg::ST_REJ_SUM] <= sum_bad; // RULE10
        status_q[ubl_pkg::ST_REJ_LDR] <= ldr_bad; // RULE21
        status_q[ubl_pkg::ST_UNUSED] <= hdr_q.ver == ubl_pkg::HDR_UNUSED;
      end
    end
  end

  chk_bus_answer: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE11
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("access not answered after one cycle");

  chk_fetch_base: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
    go && !init_s |=> o_fetch.req && o_fetch.addr == $past(data_lo_q) - ubl_pkg::HDR_OFFSET)
    else $error("fetch does not start 48 bytes before payload");

  chk_fetch_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE1
    o_fetch.req && !i_fetch_valid && !init_s |=> o_fetch.req && $stable(o_fetch.addr))
    else $error("fetch request dropped or moved before data");

  chk_word_count: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE1
    $rose(state_q == ubl_pkg::UBL_CHECK) |-> $past(idx_q) == ubl_pkg::W_LAST)
    else $error("block checked before 512 words");

  chk_high_word: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE11
    exec && msr_idx_q == ubl_pkg::MSR_TRIGGER && hi_bad && !init_s &&
    state_q == ubl_pkg::UBL_IDLE
    |=> state_q == ubl_pkg::UBL_IDLE ##0 status_q[ubl_pkg::ST_REJ_TRIG])
    else $error("trigger with nonzero high word not refused");

  chk_commit_sign: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE4
    state_q == ubl_pkg::UBL_COMMIT && !init_s |=> sign_q == $past(hdr_q.rev) && o_patch_active)
    else $error("signature not taken from revision word");

  chk_reject_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE23
    state_q == ubl_pkg::UBL_CHECK && !ok |=> $stable(sign_q) && $stable(bank_q)
    ##1 $stable(o_patch_active))
    else $error("rejected block disturbed live update");

  chk_target_ref: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE10
    state_q == ubl_pkg::UBL_CHECK && tgt_bad && !init_s
    |=> status_q[ubl_pkg::ST_REJ_TGT] && !status_q[ubl_pkg::ST_LAST_OK])
    else $error("block for another stepping accepted");

  chk_init_keeps: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE16
    init_s && o_patch_active |=> o_patch_active [*2])
    else $error("init cleared the live update");

  chk_payload_wr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE9
    mem_we |-> idx_q >= ubl_pkg::W_PAYLOAD && mem_waddr[9] != bank_q)
    else $error("payload write hits header or live bank");

  cov_commit: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    state_q == ubl_pkg::UBL_COMMIT);
  cov_rej_tgt: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    state_q == ubl_pkg::UBL_CHECK && tgt_bad);
  cov_rej_hi: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    exec && msr_idx_q == ubl_pkg::MSR_TRIGGER && hi_bad);
  cov_reload: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    go && o_patch_active);
endmodule : ubl_top

// [tb/ubl_fw_model.sv]
// Purpose: firmware-side memory that answers the loader's word fetches
// Assumes: bench writes the block image into mem; addresses wrap at 4 KiB
// Notes: i_slow adds wait cycles; idle data toggles so a stale word never looks fresh
`timescale 1ns/1ps
module ubl_fw_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire ubl_pkg::ubl_fetch_s i_fetch,
  input wire logic i_slow,
  output logic o_valid,
  output logic [31:0] o_data
);
  // whole 2048-byte block stays mapped and present, never split
  logic [7:0] mem [0:4095];
  logic [1:0] wait_q;
  logic [11:0] a;
  assign a = i_fetch.addr[11:0];
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data <= 32'h0000_0000;
      wait_q <= 2'h0;
    end else if (o_valid || !i_fetch.req) begin
      o_valid <= 1'b0;
      o_data <= ~o_data;
      wait_q <= i_slow ? 2'h2 : 2'h0;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      o_data <= ~o_data;
    end else begin
      o_valid <= 1'b1;
      o_data <= {mem[a + 12'h3], mem[a + 12'h2], mem[a + 12'h1], mem[a]};
    end
  end
endmodule : ubl_fw_model

// [tb/tb_ubl_top.sv]
// Purpose: self-checking bench for the update block loader
// Assumes: firmware model serves fetches; registers reached over Avalon-MM
// Notes: payload words derive from the revision so stale banks are visible
`timescale 1ns/1ps
module tb_ubl_top;
  localparam logic [31:0] CPU_ID = 32'h0000_0A5C; // arbitrary identity value
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_init = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  ubl_pkg::ubl_fetch_s o_fetch;
  logic fetch_valid;
  logic [31:0] fetch_data;
  logic [8:0] patch_raddr = 9'h000;
  logic [31:0] o_patch_rdata;
  logic o_patch_active;
  logic slow = 1'b0;
  logic [31:0] rd;
  logic [31:0] blk [0:511];
  int n_errors = 0;
  int tests_run = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  ubl_top #(.P_CPU_ID(CPU_ID)) u_ubl_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_init(i_init), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_fetch(o_fetch), .i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data),
    .i_patch_raddr(patch_raddr), .o_patch_rdata(o_patch_rdata),
    .o_patch_active(o_patch_active));
  ubl_fw_model u_ubl_fw_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fetch(o_fetch),
    .i_slow(slow), .o_valid(fetch_valid), .o_data(fetch_data));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] pw(input int k, input logic [31:0] rev);
    return (32'(k) * 32'h9E37_79B9) ^ rev;
  endfunction : pw
  // request held until the edge that samples waitrequest low; only the watchdog ends a hang
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge i_sys_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge i_sys_clk);
  endtask : av
  task automatic build(input logic [31:0] ver, rev, tgt, ldr, bump, input logic [11:0] base);
    logic [31:0] s;
    s = 32'h0000_0000;
    for (int k = 0; k < 512; k++) blk[k] = (k >= 12) ? pw(k - 12, rev) : 32'h0000_0000;
    blk[0] = ver;
    blk[1] = rev;
    blk[2] = 32'h0718_1995;
    blk[3] = tgt;
    blk[5] = ldr;
    for (int k = 0; k < 512; k++) s = s + blk[k];
    blk[4] = bump - s;
    for (int k = 0; k < 2048; k++) u_ubl_fw_model.mem[12'(base + k)] = blk[k / 4][8 * (k % 4) +: 8];
  endtask : build
  task automatic trig(input logic [11:0] base, input logic [31:0] hi);
    av(1'b1, ubl_pkg::REG_MSR_IDX, ubl_pkg::MSR_TRIGGER);
    av(1'b1, ubl_pkg::REG_DATA_LO, 32'(base) + ubl_pkg::HDR_OFFSET);
    av(1'b1, ubl_pkg::REG_DATA_HI, hi);
    av(1'b1, ubl_pkg::REG_CMD, 32'h0000_0001);
  endtask : trig
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      av(1'b0, ubl_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[ubl_pkg::ST_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      chk(32'h0000_0001, 32'h0000_0000);
    end
  endtask : wait_idle
  task automatic prd(input int k, input logic [31:0] exp);
    patch_raddr <= 9'(k);
    @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    chk(o_patch_rdata, exp);
  endtask : prd
  task automatic load_good(input logic [11:0] base);
    build(32'h1, 32'h10, CPU_ID, 32'h1, 32'h0, base);
    trig(base, 32'h0);
    wait_idle();
    chk(rd, 32'h0000_0006);
    av(1'b0, ubl_pkg::REG_SIGN, 32'h0);
    chk(rd, 32'h0000_0010);
    chk(32'(o_patch_active), 32'h1);
  endtask : load_good
  task automatic t_reset;
    av(1'b0, ubl_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    av(1'b0, ubl_pkg::REG_SIGN, 32'h0);
    chk(rd, 32'h0000_0000);
    av(1'b0, ubl_pkg::REG_IDENT, 32'h0);
    chk(rd, CPU_ID);
    av(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0000_0000);
    chk(32'(o_patch_active), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_good;
    slow <= 1'b1;
    load_good(12'h103);
    prd(0, pw(0, 32'h10));
    prd(1, pw(1, 32'h10));
    prd(499, pw(499, 32'h10));
    slow <= 1'b0;
    $display("test good load done");
  endtask : t_good
  task automatic t_reject;
    logic [31:0] v, t, l, b, h, e;
    for (int i = 0; i < 6; i++) begin
      {v, t, l, b, h} = {32'h1, CPU_ID, 32'h1, 32'h0, 32'h0};
      case (i)
        0: {v, e} = {32'h2, 32'h0000_0012};
        1: {v, e} = {ubl_pkg::HDR_UNUSED, 32'h0000_0112};
        2: {t, e} = {CPU_ID ^ 32'h1, 32'h0000_0022};
        3: {b, e} = {32'h1, 32'h0000_0042};
        4: {l, e} = {32'h2, 32'h0000_0082};
        default: {h, e} = {32'h1, 32'h0000_000A};
      endcase
      build(v, 32'h20, t, l, b, 12'h0);
      trig(12'h0, h);
      wait_idle();
      chk(rd, e);
      av(1'b0, ubl_pkg::REG_SIGN, 32'h0);
      chk(rd, 32'h0000_0010);
      prd(0, pw(0, 32'h10));
    end
    $display("test rejects done");
  endtask : t_reject
  task automatic t_repeat;
    load_good(12'h200);
    load_good(12'h200);
    prd(7, pw(7, 32'h10));
    $display("test repeat done");
  endtask : t_repeat
  task automatic t_init;
    i_init <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_init <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk(32'(o_patch_active), 32'h1);
    prd(3, pw(3, 32'h10));
    build(32'h1, 32'h30, CPU_ID, 32'h1, 32'h0, 12'h400);
    trig(12'h400, 32'h0);
    repeat (100) @(posedge i_sys_clk);
    i_init <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_init <= 1'b0;
    wait_idle();
    chk(rd, 32'h0000_0202);
    av(1'b0, ubl_pkg::REG_SIGN, 32'h0);
    chk(rd, 32'h0000_0010);
    $display("test init done");
  endtask : t_init
  task automatic t_hard;
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    chk(32'(o_patch_active), 32'h0);
    av(1'b0, ubl_pkg::REG_SIGN, 32'h0);
    chk(rd, 32'h0000_0000);
    load_good(12'h5F1);
    $display("test hard reset done");
  endtask : t_hard
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_reset();
    t_good();
    t_reject();
    t_repeat();
    t_init();
    t_hard();
    complete_run();
  end
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    complete_run();
  end
endmodule : tb_ubl_top
